// ---- src/hbcr_top.sv ----
// Host bus configuration registers: base decode, watermark, bus errors, burst, MAC
// Behaviour
// - Base bits 15:8 compared against bus address 15:8 for register decode.
// - Base bits 7:5 compared against address 7:5; bits 4:0 read zero.
// - With EEPROM enabled, base loads from EEPROM word 0 after reset.
// - Without EEPROM, base resets to 0x300.
// - Host writes to base change only the register, never the EEPROM.
// - Watermark bit 12: 0 selects 3 KB, 1 selects 2 KB; resets 0.
// - Bit 15 flags illegal byte enables; write one clears.
// - Illegal byte enables 3..0 captured into bits 14..11.
// - Bit 10 flags simultaneous sync and async transfers; write one clears.
// - Burst field 14:12: 000,011,101,111 for 1,4,8,16; resets 000.
// - Bank 1 is reserved except bank select at 0xE.
// - With EEPROM, MAC words load from EEPROM words 1,2,3 in order.
// - Low word holds bytes 2,1; middle 4,3; high 6,5.
// - Host writes to MAC change only the registers, not the EEPROM.
// - Programmed MAC is the accepted individual destination address.
// - Six-bit bank select at 0xE reachable in every bank.
`timescale 1ns/1ps
module hbcr_top
    import hbcr_pkg::*;
(
    input wire logic sys_clk_i, // System clock, 200 MHz
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic eeprom_enable_pin_i, // EEPROM present strap pin
    input wire hbcr_req_s req_i, // Host bus request, one cycle strobes
    input wire logic sync_xfer_i, // Synchronous transfer in progress
    input wire logic async_xfer_i, // Asynchronous transfer in progress
    input wire logic ee_ack_i, // EEPROM word ready
    input wire logic [15:0] ee_data_i, // EEPROM word data
    input wire logic [47:0] rx_da_i, // Received frame destination address
    output logic ee_req_o, // EEPROM word request
    output logic [1:0] ee_addr_o, // EEPROM word address
    output logic sel_o, // Access hits the register space
    output logic [15:0] rdata_o, // Read data, registered
    output logic rvalid_o, // Read data valid pulse
    output hbcr_cfg_s cfg_o, // Configuration to the switch
    output logic da_match_o, // Destination address equals host MAC
    output logic ready_o // Load finished, registers usable
);

    typedef struct packed {
        logic [2:0] ee_sync;
        logic [15:0] base;
        logic rx_wm;
        logic ibe_flag;
        logic [3:0] ibe_val;
        logic mix_flag;
        logic [2:0] burst;
        logic [5:0] bank;
        logic [47:0] mac;
        logic [15:0] rdata;
        logic rvalid;
    } hbcr_st_s;

    hbcr_st_s s_r;
    hbcr_st_s s_nxt;

    logic ld_we;
    logic [1:0] ld_idx;
    logic [15:0] ld_data;
    logic ld_busy;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Byte enables that are legal on a 16-bit word path
    function automatic logic be_illegal(input logic [3:0] be);
        logic bad;
        bad = 1'b1;
        unique case (be)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'hf: bad = 1'b0;
            default: bad = 1'b1;
        endcase
        return bad;
    endfunction

    // Keep the burst field at one of the documented codes
    function automatic logic [2:0] burst_legal(input logic [2:0] v, input logic [2:0] old);
        logic [2:0] r;
        r = old;
        if (v == HBCR_BURST_1 || v == HBCR_BURST_4 || v == HBCR_BURST_8 ||
            v == HBCR_BURST_16) begin
            r = v;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // EEPROM load sequencer
    // ----------------------------------------------------------------
    hbcr_eeload u_eeload (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ee_en_i(s_r.ee_sync[1]),
        .ee_ack_i(ee_ack_i),
        .ee_data_i(ee_data_i),
        .ee_req_o(ee_req_o),
        .ee_addr_o(ee_addr_o),
        .ld_we_o(ld_we),
        .ld_idx_o(ld_idx),
        .ld_data_o(ld_data),
        .ld_busy_o(ld_busy)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic hit;
    logic [3:0] off;
    logic wr;
    logic rd;

    always_comb begin
        hit = ((req_i.addr & HBCR_BASE_MASK) == (s_r.base & HBCR_BASE_MASK));
        off = req_i.addr[3:0];
        wr = req_i.wr && hit && !ld_busy;
        rd = req_i.rd && hit && !ld_busy;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.ee_sync = {s_r.ee_sync[1:0], eeprom_enable_pin_i};
        s_nxt.rvalid = rd;

        // Strap sampled at reset release selects fixed base
        if (!s_r.ee_sync[2] && s_r.ee_sync[1] == 1'b0 && ld_busy) begin
            s_nxt.base = HBCR_BASE_RST;
        end

        // EEPROM words: base, then MAC low, middle, high
        if (ld_we) begin
            if (ld_idx == HBCR_EE_WORD_BASE) begin
                s_nxt.base = ld_data & HBCR_BASE_MASK;
            end else begin
                s_nxt.mac[16*(ld_idx-HBCR_EE_WORD_MAC_LO) +: 16] = ld_data;
            end
        end

        // Host writes; nothing is sent back to the EEPROM
        if (wr) begin
            if (off == HBCR_OFF_BANK) begin
                s_nxt.bank = req_i.wdata[5:0];
            end else begin
                unique case (s_r.bank)
                    HBCR_BANK_CFG: begin
                        if (off == HBCR_OFF_BASE) begin
                            s_nxt.base = req_i.wdata & HBCR_BASE_MASK;
                        end else if (off == HBCR_OFF_RXWM) begin
                            s_nxt.rx_wm = req_i.wdata[HBCR_RXWM_BIT];
                        end else if (off == HBCR_OFF_BURST) begin
                            s_nxt.burst = burst_legal(req_i.wdata[HBCR_BURST_LSB +: 3],
                                                      s_r.burst);
                        end
                    end
                    HBCR_BANK_MAC: begin
                        if (off == HBCR_OFF_MAC_LO) begin
                            s_nxt.mac[15:0] = req_i.wdata;
                        end else if (off == HBCR_OFF_MAC_MID) begin
                            s_nxt.mac[31:16] = req_i.wdata;
                        end else if (off == HBCR_OFF_MAC_HI) begin
                            s_nxt.mac[47:32] = req_i.wdata;
                        end
                    end
                    default: begin
                        s_nxt.bank = s_r.bank;
                    end
                endcase
            end
        end

        // Write-one clears, then events set so a set wins
        if (wr && off == HBCR_OFF_BERR && s_r.bank == HBCR_BANK_CFG) begin
            if (req_i.wdata[HBCR_IBE_FLAG_BIT]) begin
                s_nxt.ibe_flag = 1'b0;
            end
            if (req_i.wdata[HBCR_MIX_FLAG_BIT]) begin
                s_nxt.mix_flag = 1'b0;
            end
        end
        if ((req_i.rd || req_i.wr) && hit && be_illegal(req_i.be)) begin
            s_nxt.ibe_flag = 1'b1;
            s_nxt.ibe_val = req_i.be;
        end
        if (sync_xfer_i && async_xfer_i) begin
            s_nxt.mix_flag = 1'b1;
        end

        // Read mux; reserved bits and banks read zero
        s_nxt.rdata = 16'h0000;
        if (rd) begin
            if (off == HBCR_OFF_BANK) begin
                s_nxt.rdata = {10'h000, s_r.bank};
            end else if (s_r.bank == HBCR_BANK_CFG) begin
                if (off == HBCR_OFF_BASE) begin
                    s_nxt.rdata = s_r.base & HBCR_BASE_MASK;
                end else if (off == HBCR_OFF_RXWM) begin
                    s_nxt.rdata[HBCR_RXWM_BIT] = s_r.rx_wm;
                end else if (off == HBCR_OFF_BERR) begin
                    s_nxt.rdata[HBCR_IBE_FLAG_BIT] = s_r.ibe_flag;
                    s_nxt.rdata[HBCR_IBE_VAL_LSB +: 4] = s_r.ibe_val;
                    s_nxt.rdata[HBCR_MIX_FLAG_BIT] = s_r.mix_flag;
                end else if (off == HBCR_OFF_BURST) begin
                    s_nxt.rdata[HBCR_BURST_LSB +: 3] = s_r.burst;
                end
            end else if (s_r.bank == HBCR_BANK_MAC) begin
                if (off == HBCR_OFF_MAC_LO) begin
                    s_nxt.rdata = s_r.mac[15:0];
                end else if (off == HBCR_OFF_MAC_MID) begin
                    s_nxt.rdata = s_r.mac[31:16];
                end else if (off == HBCR_OFF_MAC_HI) begin
                    s_nxt.rdata = s_r.mac[47:32];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_r.ee_sync <= s_nxt.ee_sync; // Strap keeps shifting so the load sees it
            s_r.base <= HBCR_BASE_RST;
            s_r.rx_wm <= 1'b0;
            s_r.ibe_flag <= 1'b0;
            s_r.ibe_val <= 4'h0;
            s_r.mix_flag <= 1'b0;
            s_r.burst <= HBCR_BURST_RST;
            s_r.bank <= HBCR_BANK_RST;
            s_r.mac <= 48'h000000000000;
            s_r.rdata <= 16'h0000;
            s_r.rvalid <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sel_o = hit;
    assign rdata_o = s_r.rdata;
    assign rvalid_o = s_r.rvalid;
    assign ready_o = !ld_busy;
    assign cfg_o = '{mac: s_r.mac, rx_wm_2k: s_r.rx_wm, burst_len: s_r.burst,
                     bank: s_r.bank};
    assign da_match_o = (rx_da_i == s_r.mac);

endmodule

// ---- inc/hbcr_pkg.sv ----
// Package of constants and carrier types for the host bus configuration registers
package hbcr_pkg;

    // ----------------------------------------------------------------
    // Register offsets (16-bit word access within a bank)
    // ----------------------------------------------------------------
    localparam logic [3:0] HBCR_OFF_BASE = 4'h0;
    localparam logic [3:0] HBCR_OFF_RXWM = 4'h4;
    localparam logic [3:0] HBCR_OFF_BERR = 4'h6;
    localparam logic [3:0] HBCR_OFF_BURST = 4'h8;
    localparam logic [3:0] HBCR_OFF_BANK = 4'he;
    localparam logic [3:0] HBCR_OFF_MAC_LO = 4'h0;
    localparam logic [3:0] HBCR_OFF_MAC_MID = 4'h2;
    localparam logic [3:0] HBCR_OFF_MAC_HI = 4'h4;

    // ----------------------------------------------------------------
    // Banks
    // ----------------------------------------------------------------
    localparam logic [5:0] HBCR_BANK_CFG = 6'h00;
    localparam logic [5:0] HBCR_BANK_MAC = 6'h02;

    // ----------------------------------------------------------------
    // Field positions and masks
    // ----------------------------------------------------------------
    localparam logic [15:0] HBCR_BASE_MASK = 16'hffe0;
    localparam int HBCR_RXWM_BIT = 12;
    localparam int HBCR_IBE_FLAG_BIT = 15;
    localparam int HBCR_IBE_VAL_LSB = 11;
    localparam int HBCR_MIX_FLAG_BIT = 10;
    localparam int HBCR_BURST_LSB = 12;
    localparam logic [15:0] HBCR_BANK_MASK = 16'h003f;

    // ----------------------------------------------------------------
    // Reset values and EEPROM word addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] HBCR_BASE_RST = 16'h0300;
    localparam logic [2:0] HBCR_BURST_RST = 3'h0;
    localparam logic [5:0] HBCR_BANK_RST = 6'h00;
    localparam logic [1:0] HBCR_EE_WORD_BASE = 2'h0;
    localparam logic [1:0] HBCR_EE_WORD_MAC_LO = 2'h1;
    localparam logic [1:0] HBCR_EE_WORD_MAC_HI = 2'h3;

    // Burst length encodings
    localparam logic [2:0] HBCR_BURST_1 = 3'h0;
    localparam logic [2:0] HBCR_BURST_4 = 3'h3;
    localparam logic [2:0] HBCR_BURST_8 = 3'h5;
    localparam logic [2:0] HBCR_BURST_16 = 3'h7;

    // Load sequencer states
    typedef enum logic [2:0] {
        HBCR_LD_REQ = 3'b001,
        HBCR_LD_WAIT = 3'b010,
        HBCR_LD_DONE = 3'b100
    } hbcr_ld_e;

    // Host bus request carrier
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [3:0] be;
        logic [15:0] wdata;
    } hbcr_req_s;

    // Configuration view driven to the rest of the switch
    typedef struct packed {
        logic [47:0] mac;
        logic rx_wm_2k;
        logic [2:0] burst_len;
        logic [5:0] bank;
    } hbcr_cfg_s;

endpackage

// ---- src/hbcr_eeload.sv ----
// EEPROM load sequencer: fetches base address and host MAC words after reset
`timescale 1ns/1ps
module hbcr_eeload
    import hbcr_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic ee_en_i, // EEPROM present (synchronised)
    input wire logic ee_ack_i, // EEPROM word ready
    input wire logic [15:0] ee_data_i, // EEPROM word data
    output logic ee_req_o, // EEPROM word request
    output logic [1:0] ee_addr_o, // EEPROM word address
    output logic ld_we_o, // Loaded word strobe
    output logic [1:0] ld_idx_o, // Loaded word index
    output logic [15:0] ld_data_o, // Loaded word data
    output logic ld_busy_o // Load still in progress
);

    typedef struct packed {
        hbcr_ld_e st;
        logic [1:0] idx;
        logic we;
        logic [15:0] data;
        logic armed;
    } hbcr_ld_s;

    hbcr_ld_s s_r;
    hbcr_ld_s s_nxt;

    // ----------------------------------------------------------------
    // Sequencer: words 0..3 in order, base first then MAC low to high
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        unique case (s_r.st)
            HBCR_LD_REQ: begin
                if (!s_r.armed) begin
                    s_nxt.armed = 1'b1;
                end else if (!ee_en_i) begin
                    s_nxt.st = HBCR_LD_DONE;
                end else begin
                    s_nxt.st = HBCR_LD_WAIT;
                end
            end
            HBCR_LD_WAIT: begin
                if (ee_ack_i) begin
                    s_nxt.we = 1'b1;
                    s_nxt.data = ee_data_i;
                    if (s_r.idx == HBCR_EE_WORD_MAC_HI) begin
                        s_nxt.st = HBCR_LD_DONE;
                    end else begin
                        s_nxt.idx = s_r.idx + 2'h1;
                    end
                end
            end
            HBCR_LD_DONE: begin
                s_nxt.st = HBCR_LD_DONE;
            end
            default: begin
                s_nxt.st = HBCR_LD_DONE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_r <= '{st: HBCR_LD_REQ, idx: HBCR_EE_WORD_BASE, we: 1'b0,
                     data: 16'h0000, armed: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ee_req_o = (s_r.st == HBCR_LD_WAIT);
    assign ee_addr_o = s_r.idx;
    assign ld_we_o = s_r.we;
    assign ld_idx_o = s_r.we ? (s_r.st == HBCR_LD_DONE ? HBCR_EE_WORD_MAC_HI
                                : s_r.idx - 2'h1) : 2'h0;
    assign ld_data_o = s_r.data;
    assign ld_busy_o = (s_r.st != HBCR_LD_DONE) || s_r.we;

endmodule

// ---- sim/hbcr_top_asserts.sv ----
// Port-level concurrent checks for the host bus configuration registers
`timescale 1ns/1ps
module hbcr_top_asserts
    import hbcr_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic sys_rst_i, // Synchronous reset
    input wire hbcr_req_s req_i, // Host bus request
    input wire logic sync_xfer_i, // Synchronous transfer
    input wire logic async_xfer_i, // Asynchronous transfer
    input wire logic ee_ack_i, // EEPROM word ready
    input wire logic [47:0] rx_da_i, // Received destination address
    input wire logic ee_req_o, // EEPROM word request
    input wire logic [1:0] ee_addr_o, // EEPROM word address
    input wire logic sel_o, // Register space hit
    input wire logic [15:0] rdata_o, // Read data
    input wire logic rvalid_o, // Read data valid
    input wire hbcr_cfg_s cfg_o, // Configuration view
    input wire logic da_match_o, // Destination address match
    input wire logic ready_o // Load finished
);
    // --------------------------------------------------------------
    // Sequences of bus steps
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Taken bank 0 accesses with a legal word enable
    sequence s_rd0(logic [3:0] off);
        req_i.rd && !req_i.wr && sel_o && ready_o && req_i.addr[3:0] == off
            && cfg_o.bank == HBCR_BANK_CFG && req_i.be inside {4'h3, 4'hf};
    endsequence
    sequence s_wr0(logic [3:0] off);
        req_i.wr && !req_i.rd && sel_o && ready_o && req_i.addr[3:0] == off
            && cfg_o.bank == HBCR_BANK_CFG && req_i.be inside {4'h3, 4'hf};
    endsequence
    sequence s_quiet;
        !req_i.rd && !req_i.wr;
    endsequence
    sequence s_bad_be;
        (req_i.rd || req_i.wr) && sel_o
            && !(req_i.be inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'hf});
    endsequence

    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    property p_rd_answer;
        req_i.rd && sel_o && ready_o |=> rvalid_o;
    endproperty
    property p_idle;
        !(req_i.rd && sel_o && ready_o) |=> !rvalid_o && rdata_o == 16'h0000;
    endproperty
    property p_base_rd;
        s_rd0(HBCR_OFF_BASE) |=> rdata_o == ($past(req_i.addr) & HBCR_BASE_MASK);
    endproperty
    property p_wm;
        s_wr0(HBCR_OFF_RXWM) |=> cfg_o.rx_wm_2k == $past(req_i.wdata[12]);
    endproperty
    property p_burst;
        s_wr0(HBCR_OFF_BURST) ##0 req_i.wdata[14:12] inside {3'h0, 3'h3, 3'h5, 3'h7}
            |=> cfg_o.burst_len == $past(req_i.wdata[14:12]);
    endproperty
    property p_bank;
        req_i.wr && sel_o && ready_o && req_i.addr[3:0] == HBCR_OFF_BANK
            && req_i.be inside {4'h3, 4'hf} |=> cfg_o.bank == $past(req_i.wdata[5:0]);
    endproperty
    property p_ibe_set;
        s_bad_be ##1 s_quiet ##1 s_rd0(HBCR_OFF_BERR)
            |=> rdata_o[15] && rdata_o[14:11] == $past(req_i.be, 3);
    endproperty
    property p_ibe_clr;
        s_wr0(HBCR_OFF_BERR) ##0 req_i.wdata[15] ##1 s_quiet ##1 s_rd0(HBCR_OFF_BERR)
            |=> !rdata_o[15];
    endproperty
    property p_mixed;
        sync_xfer_i && async_xfer_i ##1 s_quiet ##1 s_rd0(HBCR_OFF_BERR) |=> rdata_o[10];
    endproperty
    property p_ee_hold;
        ee_req_o && !ee_ack_i |=> ee_req_o && $stable(ee_addr_o);
    endproperty
    property p_ready_quiet;
        ready_o |=> ready_o && !ee_req_o;
    endproperty
    property p_da;
        da_match_o == (rx_da_i == cfg_o.mac);
    endproperty

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    a_rd_answer: assert property (p_rd_answer)
        else $error("no read valid");
    a_idle: assert property (p_idle)
        else $error("stray read data");
    a_base_rd: assert property (p_base_rd)
        else $error("base readback");
    a_wm: assert property (p_wm)
        else $error("watermark");
    a_burst: assert property (p_burst)
        else $error("burst length");
    a_bank: assert property (p_bank)
        else $error("bank select");
    a_ibe_set: assert property (p_ibe_set)
        else $error("illegal enable capture");
    a_ibe_clr: assert property (p_ibe_clr)
        else $error("illegal enable clear");
    a_mixed: assert property (p_mixed)
        else $error("mixed transfer");
    a_ee_hold: assert property (p_ee_hold)
        else $error("eeprom request not held");
    a_ready_quiet: assert property (p_ready_quiet)
        else $error("eeprom after load");
    a_da: assert property (p_da)
        else $error("address match");
endmodule

bind hbcr_top hbcr_top_asserts u_asserts (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(req_i),
    .sync_xfer_i(sync_xfer_i),
    .async_xfer_i(async_xfer_i),
    .ee_ack_i(ee_ack_i),
    .rx_da_i(rx_da_i),
    .ee_req_o(ee_req_o),
    .ee_addr_o(ee_addr_o),
    .sel_o(sel_o),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .cfg_o(cfg_o),
    .da_match_o(da_match_o),
    .ready_o(ready_o)
);

// ---- sim/hbcr_ee_model.sv ----
// Behavioural EEPROM word source answering the load sequencer
`timescale 1ns/1ps
module hbcr_ee_model (
    input wire logic sys_clk_i, // System clock
    input wire logic ee_req_i, // Word request
    input wire logic [1:0] ee_addr_i, // Word address
    input wire logic [3:0] delay_i, // Wait cycles before answering
    output logic ee_ack_o, // Word ready pulse
    output logic [15:0] ee_data_o // Word data
);
    logic [15:0] mem [4];
    logic [3:0] wait_cnt;

    // Stored words: base, then host address low, middle, high
    initial begin
        mem[0] = 16'h0a5f;
        mem[1] = 16'h89ab;
        mem[2] = 16'h4567;
        mem[3] = 16'h0123;
        ee_ack_o = 1'b0;
        ee_data_o = 16'h0000;
        wait_cnt = 4'h0;
    end

    // Answer after the set delay; data lines never keep a stale word
    always @(posedge sys_clk_i) begin
        if (!ee_req_i || ee_ack_o) begin
            ee_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            ee_data_o <= ~ee_data_o;
        end else if (wait_cnt == delay_i) begin
            ee_ack_o <= 1'b1;
            ee_data_o <= mem[ee_addr_i];
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
            ee_data_o <= ~ee_data_o;
        end
    end
endmodule

// ---- sim/hbcr_top_tb.sv ----
// Self-checking testbench for the host bus configuration registers
`timescale 1ns/1ps
module hbcr_top_tb
    import hbcr_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic strap = 1'b1;
    hbcr_req_s req = '0;
    logic sync_x = 1'b0;
    logic async_x = 1'b0;
    logic [47:0] rx_da = 48'h0;
    logic [3:0] ee_delay = 4'h5;
    logic ee_ack, ee_req, sel, rvalid, da_match, ready;
    logic [15:0] ee_data, rdata;
    logic [1:0] ee_addr;
    hbcr_cfg_s cfg;
    logic [15:0] base = 16'h0a40;
    logic [2:0] codes [4] = '{HBCR_BURST_1, HBCR_BURST_4, HBCR_BURST_8, HBCR_BURST_16};
    int bad_count = 0;
    int compares = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    hbcr_top dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .eeprom_enable_pin_i(strap),
        .req_i(req), .sync_xfer_i(sync_x), .async_xfer_i(async_x), .ee_ack_i(ee_ack),
        .ee_data_i(ee_data), .rx_da_i(rx_da), .ee_req_o(ee_req), .ee_addr_o(ee_addr),
        .sel_o(sel), .rdata_o(rdata), .rvalid_o(rvalid), .cfg_o(cfg),
        .da_match_o(da_match), .ready_o(ready));
    hbcr_ee_model u_ee (.sys_clk_i(sys_clk_i), .ee_req_i(ee_req), .ee_addr_i(ee_addr),
        .delay_i(ee_delay), .ee_ack_o(ee_ack), .ee_data_o(ee_data));

    // ----------------------------------------------------------------
    // Compare, bus and control tasks
    // ----------------------------------------------------------------
    task automatic check_val(input logic [47:0] got, input logic [47:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One-cycle read strobe; answer is looked at in the following cycle
    task automatic bus_rd(input logic [15:0] a, input logic [15:0] exp,
        input logic [15:0] mask = 16'hffff, input logic hit = 1'b1, input logic [3:0] be = 4'h3);
        @(negedge sys_clk_i);
        req.rd <= 1'b1;
        req.addr <= a;
        req.be <= be;
        @(negedge sys_clk_i);
        req.rd <= 1'b0;
        check_bit(rvalid, hit, "read valid");
        if (hit) begin
            check_val({32'h0, rdata & mask}, {32'h0, exp}, "read data");
        end
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk_i);
        req.wr <= 1'b1;
        req.addr <= a;
        req.be <= 4'h3;
        req.wdata <= d;
        @(negedge sys_clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic do_reset(input logic ee);
        int n = 0;
        strap <= ee;
        sys_rst_i <= 1'b1;
        repeat (12) @(negedge sys_clk_i);
        sys_rst_i <= 1'b0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (ready !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: load never finished", $time);
            report_and_stop();
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        bus_rd(base, 16'h0a40);
        bus_wr(base | 16'h000e, 16'h0002);
        bus_rd(base | 16'h000e, 16'h0002);
        bus_rd(base, 16'h89ab);
        bus_rd(base | 16'h0002, 16'h4567);
        bus_rd(base | 16'h0004, 16'h0123);
        check_val(cfg.mac, 48'h0123_4567_89ab, "loaded mac");
        bus_wr(base, 16'h1111);
        bus_rd(base, 16'h1111);
        check_bit(ee_req, 1'b0, "eeprom idle after write");
        rx_da = 48'h0123_4567_1111;
        @(negedge sys_clk_i);
        check_bit(da_match, 1'b1, "own address accepted");
        rx_da = 48'h0123_4567_89ab;
        @(negedge sys_clk_i);
        check_bit(da_match, 1'b0, "other address refused");
        bus_wr(base | 16'h000e, 16'h0001);
        bus_rd(base, 16'h0000);
        bus_rd(base | 16'h0008, 16'h0000);
        bus_rd(base | 16'h000e, 16'h0001);
        bus_wr(base | 16'h000e, 16'h0000);
        bus_rd(base | 16'h0004, 16'h0000);
        bus_wr(base | 16'h0004, 16'h1000);
        bus_rd(base | 16'h0004, 16'h1000);
        check_bit(cfg.rx_wm_2k, 1'b1, "watermark 2k");
        bus_rd(base | 16'h0008, 16'h0000);
        for (int i = 3; i >= 0; i--) begin
            bus_wr(base | 16'h0008, {1'b0, codes[i], 12'h000});
            bus_rd(base | 16'h0008, {1'b0, codes[i], 12'h000});
            check_val({45'h0, cfg.burst_len}, {45'h0, codes[i]}, "burst field");
        end
        bus_rd(base | 16'h0008, 16'h0000, 16'h0000, 1'b1, 4'h5);
        bus_rd(base | 16'h0006, 16'ha800, 16'hfc00);
        bus_wr(base | 16'h0006, 16'h8000);
        bus_rd(base | 16'h0006, 16'h0000, 16'h8400);
        sync_x = 1'b1;
        @(negedge sys_clk_i);
        sync_x = 1'b0;
        bus_rd(base | 16'h0006, 16'h0000, 16'h0400);
        sync_x = 1'b1;
        async_x = 1'b1;
        @(negedge sys_clk_i);
        sync_x = 1'b0;
        async_x = 1'b0;
        bus_rd(base | 16'h0006, 16'h0400, 16'h0400);
        bus_wr(base | 16'h0006, 16'h0400);
        bus_rd(base | 16'h0006, 16'h0000, 16'h0400);
        bus_wr(base, 16'h4567);
        check_bit(ee_req, 1'b0, "eeprom idle after base write");
        bus_rd(16'h0a40, 16'h0000, 16'hffff, 1'b0);
        bus_rd(16'h4560, 16'h4560);
        bus_rd(16'h4540, 16'h0000, 16'hffff, 1'b0);
        bus_rd(16'h4460, 16'h0000, 16'hffff, 1'b0);
        ee_delay = 4'h0;
        do_reset(1'b1);
        bus_rd(16'h0a40, 16'h0a40);
        do_reset(1'b0);
        bus_rd(16'h0300, 16'h0300);
        bus_rd(16'h0308, 16'h0000);
        bus_rd(16'h0a40, 16'h0000, 16'hffff, 1'b0);
        report_and_stop();
    end
endmodule
